// file: sim/adcct_bench.sv
// Self-checking testbench of the ADC compute block.
`timescale 1ns/1ps
`default_nettype none
module adcct_bench
  import adcct_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, trigger, sampling, threshold_check;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [9:0] sample_in, s1, s2;
  logic [4:0] extra_capacitor_field;
  logic [15:0] v, e;
  logic [7:0] ra [4];
  int err_total, cmp_count, chk_cnt, seed, n, d0, dl, hi;

  adcct_top i_adcct_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trigger, .sample_in, .extra_capacitor_field,
    .sampling, .threshold_check);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (threshold_check === 1'b1) chk_cnt <= chk_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 40);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 40) err_total++;
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 40);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 40) err_total++;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    rd(a);
    chk(rv & m, exp);
  endtask

  task automatic rc16(input logic [7:0] ah, input logic [7:0] al,
                      input logic [15:0] exp);
    rc(ah, 32'hff, {24'h0, exp[15:8]});
    rc(al, 32'hff, {24'h0, exp[7:0]});
  endtask

  // Trigger is held through the whole conversion so the sample stays put.
  task automatic cv(input logic [9:0] s);
    int k;
    k = 0;
    sample_in <= s;
    trigger <= 1'b1;
    while (sampling !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
    end
    while (sampling === 1'b1 && k < 400) begin
      @(posedge aclk);
      k++;
    end
    repeat (30) @(posedge aclk);
    trigger <= 1'b0;
    repeat (4) @(posedge aclk);
    if (k >= 400) err_total++;
  endtask

  task automatic ms(input logic [31:0] pre, input logic [31:0] acq);
    wr(OFS_PRECHARGE, pre);
    wr(OFS_ACQUISITION, acq);
    trigger <= 1'b1;
    dl = 0;
    hi = 0;
    while (sampling !== 1'b1 && dl < 600) begin
      @(posedge aclk);
      dl++;
    end
    while (sampling === 1'b1 && hi < 600) begin
      @(posedge aclk);
      hi++;
    end
    repeat (30) @(posedge aclk);
    trigger <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    repeat (50000) @(posedge aclk);
    err_total++;
    summarize();
  end

  initial begin
    seed = 32'he7f7f817;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, trigger} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    sample_in = 10'h000;
    ra = '{OFS_REPEAT_THR, OFS_REPEAT_CNT, OFS_SETPOINT_HIGH, OFS_SETPOINT_LOW};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(OFS_PRECHARGE, 32'hff, 32'h0);
    rc(OFS_ACQUISITION, 32'hff, 32'h0);
    rc(OFS_CAPACITOR, 32'hff, 32'h0);
    rc(OFS_REPEAT_THR, 32'hff, 32'h0);
    rd(8'h80);
    chk({rv[31:2], rr}, {30'h0, RESP_SLVERR});
    wr(8'h84, 32'h1);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    v = 16'($random(seed));
    wr(OFS_CAPACITOR, {16'h0, v});
    chk({27'h0, extra_capacitor_field}, {27'h0, v[4:0]});
    rc(OFS_CAPACITOR, 32'hff, {27'h0, v[4:0]});
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      wr(ra[i], {24'h0, v[7:0]});
      rc(ra[i], 32'hff, {24'h0, v[7:0]});
    end
    for (int m = 0; m < 5; m++) begin
      wr(OFS_CONTROL, m);
      rc(OFS_CONTROL, 32'h7, m);
    end
    wr(OFS_CONTROL, 32'h0);
    ms(32'h0, 32'h3);
    d0 = dl;
    chk(hi, 32'h3);
    ms(32'h5, 32'h3);
    chk(dl, d0 + 5);
    ms(32'h2, 32'h0);
    chk(hi, 32'h100);
    ms(32'h0, 32'h0);
    chk(hi, 32'h0);
    ms(32'h0, 32'hff);
    chk(hi, 32'hff);
    // A slower converter clock stretches every phase by the same factor.
    wr(OFS_CONTROL, 32'h10000);
    ms(32'h0, 32'h3);
    chk(hi, 32'h6);
    wr(OFS_ACQUISITION, 32'h2);
    wr(OFS_CONTROL, 32'h0);
    s1 = 10'($random(seed));
    n = chk_cnt;
    cv(s1);
    chk(chk_cnt - n, 32'h1);
    rc(OFS_RESULT_HIGH, 32'hff, {24'h0, s1[9:2]});
    rc(OFS_RESULT_LOW, 32'hc0, {24'h0, s1[1:0], 6'h0});
    wr(OFS_CONTROL, 32'h100);
    s2 = 10'($random(seed));
    cv(s2);
    rc(OFS_RESULT_HIGH, 32'h3, {30'h0, s2[9:8]});
    rc(OFS_RESULT_LOW, 32'hff, {24'h0, s2[7:0]});
    rc(OFS_PREV_HIGH, 32'h3, {30'h0, s1[9:8]});
    rc(OFS_PREV_LOW, 32'hff, {24'h0, s1[7:0]});
    wr(OFS_REPEAT_CNT, 32'h5a);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(OFS_CONTROL, 32'h100);
    rc(OFS_RESULT_LOW, 32'hff, {24'h0, s2[7:0]});
    rc(OFS_REPEAT_CNT, 32'hff, 32'h5a);
    wr(OFS_ACQUISITION, 32'h2);
    wr(OFS_CONTROL, 32'h99);
    wr(OFS_CONTROL, 32'h91);
    rc16(OFS_ACC_HIGH, OFS_ACC_LOW, 16'h0);
    rc(OFS_REPEAT_CNT, 32'hff, 32'h0);
    s1 = 10'($random(seed));
    s2 = 10'($random(seed));
    cv(s1);
    cv(s2);
    e = 16'(s1) + 16'(s2);
    rc16(OFS_ACC_HIGH, OFS_ACC_LOW, e);
    rc16(OFS_FILTER_HIGH, OFS_FILTER_LOW, e >> 1);
    rc16(OFS_PREV_HIGH, OFS_PREV_LOW, 16'(s1) >> 1);
    rc(OFS_REPEAT_CNT, 32'hff, 32'h2);
    wr(OFS_REPEAT_THR, 32'h3);
    wr(OFS_CONTROL, 32'h0a);
    wr(OFS_CONTROL, 32'h02);
    n = chk_cnt;
    cv(10'($random(seed)));
    cv(10'($random(seed)));
    chk(chk_cnt - n, 32'h0);
    cv(10'($random(seed)));
    chk(chk_cnt - n, 32'h1);
    wr(OFS_CONTROL, 32'h24);
    v = 16'($random(seed)) & 16'h3fff;
    wr(OFS_ACC_HIGH, {24'h0, v[15:8]});
    wr(OFS_ACC_LOW, {24'h0, v[7:0]});
    rc16(OFS_ACC_HIGH, OFS_ACC_LOW, v);
    s1 = 10'($random(seed));
    cv(s1);
    e = v - (v >> 2) + 16'(s1);
    rc16(OFS_FILTER_HIGH, OFS_FILTER_LOW, e >> 2);
    summarize();
  end
endmodule

bind adcct_top adcct_checker i_adcct_checker (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sampling(sampling), .threshold_check(threshold_check));
`default_nettype wire

// file: sim/adcct_checker.sv
// Checker with bus and output timing properties of the ADC compute block.
`timescale 1ns/1ps
`default_nettype none
module adcct_checker
  import adcct_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sampling,
  input wire logic threshold_check
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response withdrawn early");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_chk_pulse: assert property (threshold_check |=> !threshold_check)
    else $error("check pulse longer than one cycle");
  a_chk_idle: assert property (threshold_check |-> !sampling)
    else $error("check raised during acquisition");
  a_quiet_release: assert property ($rose(aresetn)
    |-> !sampling && !threshold_check && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  cover property ($fell(sampling));
  cover property (threshold_check);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// file: src/adcct_pkg.sv
// Package with register map, field layout and encodings of the ADC compute block.
package adcct_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PRECHARGE = 8'h00;
  localparam logic [7:0] OFS_ACQUISITION = 8'h04;
  localparam logic [7:0] OFS_CAPACITOR = 8'h08;
  localparam logic [7:0] OFS_REPEAT_THR = 8'h0c;
  localparam logic [7:0] OFS_REPEAT_CNT = 8'h10;
  localparam logic [7:0] OFS_FILTER_HIGH = 8'h14;
  localparam logic [7:0] OFS_FILTER_LOW = 8'h18;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h1c;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h20;
  localparam logic [7:0] OFS_PREV_HIGH = 8'h24;
  localparam logic [7:0] OFS_PREV_LOW = 8'h28;
  localparam logic [7:0] OFS_ACC_HIGH = 8'h2c;
  localparam logic [7:0] OFS_ACC_LOW = 8'h30;
  localparam logic [7:0] OFS_SETPOINT_HIGH = 8'h34;
  localparam logic [7:0] OFS_SETPOINT_LOW = 8'h38;
  localparam logic [7:0] OFS_CONTROL = 8'h3c;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  // Control register layout.
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_CLEAR_BIT = 3;
  localparam int CTL_SHIFT_LSB = 4;
  localparam int CTL_PSIS_BIT = 7;
  localparam int CTL_JUSTIFY_BIT = 8;
  localparam int CTL_GO_BIT = 9;
  localparam int CTL_CLKDIV_LSB = 16;
  // Status register layout.
  localparam int STS_PHASE_LSB = 0;
  localparam int STS_CHECK_BIT = 4;
  localparam int STS_OVF_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [8:0] ACQ_FULL = 9'h100;
  localparam logic [8:0] CONV_CLOCKS = 9'h00b;
  localparam logic [15:0] ACC_UNKNOWN = 16'h0000;
  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACCUM = 3'h1;
  localparam logic [2:0] MODE_AVG = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LPF = 3'h4;
  localparam logic [2:0] PH_IDLE = 3'h0;
  localparam logic [2:0] PH_PRE = 3'h1;
  localparam logic [2:0] PH_ACQ = 3'h2;
  localparam logic [2:0] PH_CONV = 3'h3;
  typedef enum logic [3:0] {
    ADCCT_IDLE = 4'b0001,
    ADCCT_PRE = 4'b0010,
    ADCCT_ACQ = 4'b0100,
    ADCCT_CONV = 4'b1000
  } adcct_state_t;
  typedef struct packed {
    logic [2:0] compute_mode;
    logic [2:0] shift_field;
    logic previous_source_bit;
    logic justify_bit;
  } adcct_ctl_t;
endpackage

// file: src/adcct_top.sv
// ADC compute block: timing sequencer, compute datapath and AXI4-Lite registers.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adcct_top
  import adcct_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger,
  input wire logic [9:0] sample_in,
  output logic [4:0] extra_capacitor_field,
  output logic sampling,
  output logic threshold_check
);
  logic [7:0] precharge_count;
  logic [7:0] acquisition_count;
  logic [7:0] repeat_threshold;
  logic [7:0] repeat_counter;
  logic [15:0] accumulator_value;
  logic [15:0] filter_output;
  logic [15:0] previous_value;
  logic [15:0] threshold_setpoint;
  logic [15:0] result_word;
  logic [9:0] conversion_result;
  logic accumulator_overflow_flag;
  logic accumulator_clear_command;
  logic go;
  logic [7:0] clk_div;
  logic [7:0] div_cnt;
  logic tick;
  adcct_ctl_t ctl;
  adcct_state_t state;
  logic [8:0] phase_cnt;
  logic [1:0] trig_sync;
  logic trig_d;
  logic [9:0] sample_s1;
  logic [9:0] sample_s2;
  logic conv_done;
  logic conv_start;
  logic [16:0] acc_sum;
  logic [15:0] lpf_next;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] next_rdata;
  logic rd_ok;

  // Restart the divider at each start so every phase has a fixed length.
  always_ff @(posedge aclk) begin
    if (!aresetn || conv_start || div_cnt >= clk_div) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign tick = (div_cnt >= clk_div);

  // The trigger and sample come from outside the clock domain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sync <= 2'b00;
      trig_d <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], trigger};
      trig_d <= trig_sync[1];
    end
  end
  always_ff @(posedge aclk) begin
    sample_s1 <= sample_in;
    sample_s2 <= sample_s1;
  end

  assign conv_start = (state == ADCCT_IDLE) && (go || (trig_sync[1] && !trig_d));
  assign conv_done = (state == ADCCT_CONV) && tick && (phase_cnt == 9'h001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ADCCT_IDLE;
      phase_cnt <= 9'h000;
    end else begin
      unique case (state)
        ADCCT_IDLE: begin
          if (conv_start) begin
            if (precharge_count != 8'h00) begin
              state <= ADCCT_PRE;
              phase_cnt <= {1'b0, precharge_count};
            end else if (acquisition_count != 8'h00) begin
              state <= ADCCT_ACQ;
              phase_cnt <= {1'b0, acquisition_count};
            end else begin
              state <= ADCCT_CONV;
              phase_cnt <= CONV_CLOCKS;
            end
          end
        end
        ADCCT_PRE: begin
          if (tick && phase_cnt == 9'h001) begin
            state <= ADCCT_ACQ;
            phase_cnt <= (acquisition_count == 8'h00) ? ACQ_FULL
                       : {1'b0, acquisition_count};
          end else if (tick) begin
            phase_cnt <= phase_cnt - 9'h001;
          end
        end
        ADCCT_ACQ: begin
          if (tick && phase_cnt == 9'h001) begin
            state <= ADCCT_CONV;
            phase_cnt <= CONV_CLOCKS;
          end else if (tick) begin
            phase_cnt <= phase_cnt - 9'h001;
          end
        end
        ADCCT_CONV: begin
          if (conv_done) begin
            state <= ADCCT_IDLE;
          end else if (tick) begin
            phase_cnt <= phase_cnt - 9'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampling <= 1'b0;
    end else begin
      sampling <= (state == ADCCT_ACQ);
    end
  end

  // Justified layout of the result as seen in the two bytes.
  always_comb begin
    if (ctl.justify_bit) begin
      result_word = {6'h00, conversion_result};
    end else begin
      result_word = {conversion_result, 6'h00};
    end
  end

  // Average and burst modes divide by a power of two; filter smooths.
  assign acc_sum = {1'b0, accumulator_value} + {7'h00, sample_s2};
  assign lpf_next = accumulator_value - (accumulator_value >> ctl.shift_field)
                  + {6'h00, sample_s2};

  // Result and accumulator keep contents across reset.
  always_ff @(posedge aclk) begin
    if (wr_go && aw_addr == OFS_RESULT_HIGH) begin
      if (ctl.justify_bit) begin
        conversion_result[9:8] <= w_data[1:0];
      end else begin
        conversion_result[9:2] <= w_data[7:0];
      end
    end else if (wr_go && aw_addr == OFS_RESULT_LOW) begin
      if (ctl.justify_bit) begin
        conversion_result[7:0] <= w_data[7:0];
      end else begin
        conversion_result[1:0] <= w_data[7:6];
      end
    end else if (conv_done) begin
      conversion_result <= sample_s2;
    end
  end

  always_ff @(posedge aclk) begin
    if (accumulator_clear_command) begin
      accumulator_value <= ACC_UNKNOWN;
    end else if (wr_go && aw_addr == OFS_ACC_HIGH) begin
      accumulator_value[15:8] <= w_data[7:0];
    end else if (wr_go && aw_addr == OFS_ACC_LOW) begin
      accumulator_value[7:0] <= w_data[7:0];
    end else if (conv_done) begin
      unique case (ctl.compute_mode)
        MODE_ACCUM, MODE_AVG, MODE_BURST: accumulator_value <= acc_sum[15:0];
        MODE_LPF: accumulator_value <= lpf_next;
        default: accumulator_value <= accumulator_value;
      endcase
    end
  end

  always_comb begin
    if (ctl.compute_mode == MODE_LPF) begin
      filter_output = accumulator_value >> ctl.shift_field;
    end else begin
      filter_output = accumulator_value >> ctl.shift_field;
    end
  end

  always_ff @(posedge aclk) begin
    if (conv_start) begin
      previous_value <= ctl.previous_source_bit ? filter_output
                      : result_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (accumulator_clear_command) begin
      repeat_counter <= 8'h00;
    end else if (wr_go && aw_addr == OFS_REPEAT_CNT) begin
      repeat_counter <= w_data[7:0];
    end else if (conv_done && ctl.compute_mode != MODE_BASIC) begin
      repeat_counter <= repeat_counter + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_check <= 1'b0;
    end else if (ctl.compute_mode == MODE_AVG || ctl.compute_mode == MODE_BURST
                 || ctl.compute_mode == MODE_LPF) begin
      threshold_check <= conv_done
                       && (repeat_counter + 8'h01 >= repeat_threshold);
    end else begin
      threshold_check <= conv_done;
    end
  end

  // Overflow: a set in the clearing cycle is dropped since clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn || accumulator_clear_command) begin
      accumulator_overflow_flag <= 1'b0;
    end else if (conv_done && ctl.compute_mode != MODE_BASIC && acc_sum[16]) begin
      accumulator_overflow_flag <= 1'b1;
    end
  end

  // Control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      precharge_count <= 8'h00;
      acquisition_count <= 8'h00;
      extra_capacitor_field <= 5'h00;
      repeat_threshold <= 8'h00;
      ctl <= '0;
      clk_div <= 8'h00;
      go <= 1'b0;
      accumulator_clear_command <= 1'b0;
    end else begin
      go <= 1'b0;
      accumulator_clear_command <= 1'b0;
      if (wr_go && w_strb[0]) begin
        unique case (aw_addr)
          OFS_PRECHARGE: precharge_count <= w_data[7:0];
          OFS_ACQUISITION: acquisition_count <= w_data[7:0];
          OFS_CAPACITOR: extra_capacitor_field <= w_data[4:0];
          OFS_REPEAT_THR: repeat_threshold <= w_data[7:0];
          OFS_CONTROL: begin
            ctl.compute_mode <= w_data[CTL_MODE_LSB +: 3];
            ctl.shift_field <= w_data[CTL_SHIFT_LSB +: 3];
            ctl.previous_source_bit <= w_data[CTL_PSIS_BIT];
            ctl.justify_bit <= w_data[CTL_JUSTIFY_BIT];
            accumulator_clear_command <= w_data[CTL_CLEAR_BIT];
            go <= w_data[CTL_GO_BIT];
            clk_div <= w_data[CTL_CLKDIV_LSB +: 8];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_go && aw_addr == OFS_SETPOINT_HIGH) begin
      threshold_setpoint[15:8] <= w_data[7:0];
    end else if (wr_go && aw_addr == OFS_SETPOINT_LOW) begin
      threshold_setpoint[7:0] <= w_data[7:0];
    end
  end

  // AXI4-Lite write path: address and data in either order.
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= OFS_CONTROL && aw_addr[1:0] == 2'b00)
                     ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_PRECHARGE: next_rdata[7:0] = precharge_count;
      OFS_ACQUISITION: next_rdata[7:0] = acquisition_count;
      OFS_CAPACITOR: next_rdata[4:0] = extra_capacitor_field;
      OFS_REPEAT_THR: next_rdata[7:0] = repeat_threshold;
      OFS_REPEAT_CNT: next_rdata[7:0] = repeat_counter;
      OFS_FILTER_HIGH: next_rdata[7:0] = filter_output[15:8];
      OFS_FILTER_LOW: next_rdata[7:0] = filter_output[7:0];
      OFS_RESULT_HIGH: next_rdata[7:0] = result_word[15:8];
      OFS_RESULT_LOW: next_rdata[7:0] = result_word[7:0];
      OFS_PREV_HIGH: next_rdata[7:0] = previous_value[15:8];
      OFS_PREV_LOW: next_rdata[7:0] = previous_value[7:0];
      OFS_ACC_HIGH: next_rdata[7:0] = accumulator_value[15:8];
      OFS_ACC_LOW: next_rdata[7:0] = accumulator_value[7:0];
      OFS_SETPOINT_HIGH: next_rdata[7:0] = threshold_setpoint[15:8];
      OFS_SETPOINT_LOW: next_rdata[7:0] = threshold_setpoint[7:0];
      OFS_CONTROL: begin
        next_rdata[CTL_MODE_LSB +: 3] = ctl.compute_mode;
        next_rdata[CTL_CLEAR_BIT] = accumulator_clear_command;
        next_rdata[CTL_SHIFT_LSB +: 3] = ctl.shift_field;
        next_rdata[CTL_PSIS_BIT] = ctl.previous_source_bit;
        next_rdata[CTL_JUSTIFY_BIT] = ctl.justify_bit;
        next_rdata[CTL_CLKDIV_LSB +: 8] = clk_div;
      end
      OFS_STATUS: begin
        next_rdata[STS_PHASE_LSB +: 3] = (state == ADCCT_PRE) ? PH_PRE
          : (state == ADCCT_ACQ) ? PH_ACQ
          : (state == ADCCT_CONV) ? PH_CONV : PH_IDLE;
        next_rdata[STS_CHECK_BIT] = threshold_check;
        next_rdata[STS_OVF_BIT] = accumulator_overflow_flag;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
